// file: hw/dlrc_pkg.sv
// shared constants for the dac load and reset control block
package dlrc_pkg;
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam int NUM_CHAN = 8;
  localparam int CODE_BITS = 16;
  // command codes
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE_SEL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
  localparam logic [3:0] CMD_REF_GAIN = 4'h7;
  // software reset key
  localparam logic [3:0] SOFT_RESET_ADDR = 4'h0;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h1234;
  // setup field positions
  localparam int SETUP_GAIN_BIT = 2;
  localparam int SETUP_REF_BIT = 0;
  // reset values
  localparam logic [7:0] LOAD_MASK_RST = 8'h00;
  localparam logic SETUP_GAIN_RST = 1'b0;
  localparam logic SETUP_REF_RST = 1'b0;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [23:0] SHIFT_RST = 24'h000000;
  localparam logic [2:0] SYNC_RST = 3'h0;
  // control states
  typedef enum logic [1:0] {
    DLRC_INIT = 2'b01,
    DLRC_RUN = 2'b10
  } dlrc_state_t;
endpackage : dlrc_pkg

// file: hw/dlrc_top.sv
// load, mask, clear and setup control for an eight-channel dac
// ---------------------------------------------------------------
// What this block does
// - strobe high during input writes; its fall updates unmasked channels.
// - command 0101 loads the 8-bit load mask from data bits 7..0.
// - load mask resets to zero, every channel follows the strobe.
// - a masked channel ignores strobe falls; a low strobe still updates it on input writes.
// - command 0001 writes input; dac also updated when strobe is low.
// - command 0010 copies input to selected dac registers, strobe ignored.
// - command 0011 writes both input and dac register of channel.
// - a strobe falling edge after init, with clear high, copies input to dac on unmasked channels.
// - strobe held low means the mask bits are disregarded.
// - clear pin low forces outputs to zero or midscale per select pin.
// - after clear release outputs hold cleared value until reprogrammed.
// - while clear pin is low no frame or strobe changes any output.
// - strobe activity ignored during power-on reset; clear pin low only delays it.
// - clear pin low at power-up holds off initialisation until released.
// - power-up code is zero or midscale per select pin, held until write.
// - variants without the select pin power up to zero.
// - command 0110 resets to power-on code only with address 0, data 1234h.
// - command 0111 writes setup: bit 2 gain, bit 1 zero, bit 0 reference.
// - setup bit two selects gain one (default) or gain two.
// - setup bit zero keeps reference enabled (default) or disables it.
// - 24-bit word shifted in while frame sync low, acted on at its rise.
// - command 0010 data bits 7..0 select channels to transfer.
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module dlrc_top #(
  parameter int NUM_CHAN = dlrc_pkg::NUM_CHAN,
  parameter int CODE_BITS = dlrc_pkg::CODE_BITS,
  parameter bit HAS_CLEAR_SELECT = 1'b1
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SCLK,
  input wire logic SYNC_N,
  input wire logic SDI,
  input wire logic LOAD_STROBE_N,
  input wire logic CLEAR_N,
  input wire logic CLEAR_LEVEL_SELECT,
  output logic [NUM_CHAN-1:0][CODE_BITS-1:0] DAC_CODE,
  output logic [NUM_CHAN-1:0] LOAD_MASK,
  output logic GAIN_TWO,
  output logic REF_DISABLE,
  output logic INIT_DONE
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // one-hot channel select; addresses beyond the channel count select none
  function automatic logic [NUM_CHAN-1:0] chan_sel(input logic [3:0] addr);
    logic [NUM_CHAN-1:0] sel;
    sel = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (addr == 4'(i)) begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction : chan_sel

  // clear or power-on code chosen by a select level
  function automatic logic [CODE_BITS-1:0] level_code(input logic mid);
    logic [CODE_BITS-1:0] code;
    code = mid ? CODE_BITS'(dlrc_pkg::CODE_MID) :
                 CODE_BITS'(dlrc_pkg::CODE_ZERO);
    return code;
  endfunction : level_code

  // ---------------------------------------------------------------
  // link domain: serial shift register on the serial clock
  // ---------------------------------------------------------------
  logic [dlrc_pkg::FRAME_BITS-1:0] shift_reg;
  logic [dlrc_pkg::FRAME_BITS-1:0] shift_next;

  // shift while framed
  // msb first; sclk may stop outside frames, so the word just holds
  // no synchroniser on the word: it is quiet for clocks before it is read
  always_comb begin
    shift_next = shift_reg;
    if (!SYNC_N) begin
      shift_next = {shift_reg[dlrc_pkg::FRAME_BITS-2:0], SDI};
    end
  end

  // link side register
  always_ff @(posedge SCLK or negedge RSTN) begin
    if (!RSTN) begin
      shift_reg <= dlrc_pkg::SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers into the system clock domain
  // ---------------------------------------------------------------
  // frame sync gets a third stage for its edge; strobe likewise
  // limitation: pin pulses shorter than one clock can be missed
  logic [2:0] sync_pipe_reg;
  logic [2:0] sync_pipe_next;
  logic [2:0] strobe_pipe_reg;
  logic [2:0] strobe_pipe_next;
  logic [1:0] clear_pipe_reg;
  logic [1:0] clear_pipe_next;
  logic [1:0] level_pipe_reg;
  logic [1:0] level_pipe_next;

  // shift chains; the first stage feeds only the second
  always_comb begin
    sync_pipe_next = {sync_pipe_reg[1:0], SYNC_N};
    strobe_pipe_next = {strobe_pipe_reg[1:0], LOAD_STROBE_N};
    clear_pipe_next = {clear_pipe_reg[0], CLEAR_N};
    level_pipe_next = {level_pipe_reg[0], CLEAR_LEVEL_SELECT};
  end

  // idle levels: sync and strobe inactive high
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_pipe_reg <= ~dlrc_pkg::SYNC_RST;
      strobe_pipe_reg <= ~dlrc_pkg::SYNC_RST;
      // clear starts asserted so init waits for the real pin level;
      // an idle-high reset value would let init finish on a stale level
      clear_pipe_reg <= dlrc_pkg::SYNC_RST[1:0];
      level_pipe_reg <= dlrc_pkg::SYNC_RST[1:0];
    end else begin
      sync_pipe_reg <= sync_pipe_next;
      strobe_pipe_reg <= strobe_pipe_next;
      clear_pipe_reg <= clear_pipe_next;
      level_pipe_reg <= level_pipe_next;
    end
  end

  logic frame_end;
  logic strobe_fall;
  logic strobe_low;
  logic clear_low;
  logic clear_mid;

  // edges only from the settled stages
  assign frame_end = sync_pipe_reg[1] & ~sync_pipe_reg[2];
  assign strobe_fall = ~strobe_pipe_reg[1] & strobe_pipe_reg[2];
  assign strobe_low = ~strobe_pipe_reg[1];
  assign clear_low = ~clear_pipe_reg[1];
  assign clear_mid = HAS_CLEAR_SELECT & level_pipe_reg[1];

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  // the word is stable here: shifting stopped two clocks before the edge
  // a frame cut short still decodes the last bits that were shifted
  logic [3:0] f_cmd;
  logic [3:0] f_addr;
  logic [15:0] f_data;
  logic [NUM_CHAN-1:0] f_sel;

  assign f_cmd = shift_reg[dlrc_pkg::CMD_MSB:dlrc_pkg::CMD_LSB];
  assign f_addr = shift_reg[dlrc_pkg::ADDR_MSB:dlrc_pkg::ADDR_LSB];
  assign f_data = shift_reg[dlrc_pkg::DATA_MSB:dlrc_pkg::DATA_LSB];
  assign f_sel = chan_sel(f_addr);

  // ---------------------------------------------------------------
  // control state and channel registers
  // ---------------------------------------------------------------
  dlrc_pkg::dlrc_state_t state_reg;
  dlrc_pkg::dlrc_state_t state_next;
  logic por_mid_reg;
  logic por_mid_next;
  logic [NUM_CHAN-1:0] mask_reg;
  logic [NUM_CHAN-1:0] mask_next;
  logic gain_reg;
  logic gain_next;
  logic ref_off_reg;
  logic ref_off_next;
  logic [NUM_CHAN-1:0][CODE_BITS-1:0] input_reg;
  logic [NUM_CHAN-1:0][CODE_BITS-1:0] input_next;
  logic [NUM_CHAN-1:0][CODE_BITS-1:0] dac_reg;
  logic [NUM_CHAN-1:0][CODE_BITS-1:0] dac_next;

  // next-state and datapath; clear beats frames and strobes
  always_comb begin
    logic [NUM_CHAN-1:0] xfer;
    logic [NUM_CHAN-1:0] wr;
    logic key_ok;
    xfer = '0;
    wr = '0;
    key_ok = (f_addr == dlrc_pkg::SOFT_RESET_ADDR) &&
             (f_data == dlrc_pkg::SOFT_RESET_KEY);
    state_next = state_reg;
    por_mid_next = por_mid_reg;
    mask_next = mask_reg;
    gain_next = gain_reg;
    ref_off_next = ref_off_reg;
    input_next = input_reg;
    dac_next = dac_reg;
    unique case (state_reg)
      dlrc_pkg::DLRC_INIT: begin
        // strobe ignored here; clear low holds init
        // frames are dropped too, nothing is ready yet
        if (!clear_low) begin
          state_next = dlrc_pkg::DLRC_RUN;
          // zero without select
          // the missing pin is folded into clear_mid
          por_mid_next = clear_mid;
          for (int i = 0; i < NUM_CHAN; i++) begin
            input_next[i] = level_code(clear_mid);
            dac_next[i] = level_code(clear_mid);
          end
        end
      end
      dlrc_pkg::DLRC_RUN: begin
        if (clear_low) begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            input_next[i] = level_code(clear_mid);
            dac_next[i] = level_code(clear_mid);
          end
        end else begin
          // masked channels never see the edge
          if (strobe_fall) begin
            xfer = ~mask_reg;
          end
          if (frame_end) begin
            unique case (f_cmd)
              dlrc_pkg::CMD_WRITE_INPUT: begin
                // input always, dac when strobe low
                // a low strobe overrides the mask
                // high strobe defers to the later fall
                wr = f_sel;
                for (int i = 0; i < NUM_CHAN; i++) begin
                  if (f_sel[i]) begin
                    input_next[i] = f_data[CODE_BITS-1:0];
                    if (strobe_low) begin
                      dac_next[i] = f_data[CODE_BITS-1:0];
                    end
                  end
                end
              end
              dlrc_pkg::CMD_UPDATE_SEL: begin
                xfer = xfer | f_data[NUM_CHAN-1:0];
              end
              dlrc_pkg::CMD_WRITE_UPDATE: begin
                wr = f_sel;
                for (int i = 0; i < NUM_CHAN; i++) begin
                  if (f_sel[i]) begin
                    input_next[i] = f_data[CODE_BITS-1:0];
                    dac_next[i] = f_data[CODE_BITS-1:0];
                  end
                end
              end
              dlrc_pkg::CMD_LOAD_MASK: begin
                mask_next = f_data[NUM_CHAN-1:0];
              end
              dlrc_pkg::CMD_SOFT_RESET: begin
                if (key_ok) begin
                  xfer = '0;
                  mask_next = NUM_CHAN'(dlrc_pkg::LOAD_MASK_RST);
                  gain_next = dlrc_pkg::SETUP_GAIN_RST;
                  ref_off_next = dlrc_pkg::SETUP_REF_RST;
                  for (int i = 0; i < NUM_CHAN; i++) begin
                    input_next[i] = level_code(por_mid_reg);
                    dac_next[i] = level_code(por_mid_reg);
                  end
                end
              end
              dlrc_pkg::CMD_REF_GAIN: begin
                gain_next = f_data[dlrc_pkg::SETUP_GAIN_BIT];
                ref_off_next = f_data[dlrc_pkg::SETUP_REF_BIT];
              end
              default: begin
                // other commands belong to neighbouring logic
              end
            endcase
          end
          // transfers read the input registers as they stood;
          // fresh frame data on a channel beats a same-cycle strobe transfer
          for (int i = 0; i < NUM_CHAN; i++) begin
            if (xfer[i] && !wr[i]) begin
              dac_next[i] = input_reg[i];
            end
          end
        end
      end
      default: begin
        // illegal one-hot code recovers through init
        state_next = dlrc_pkg::DLRC_INIT;
      end
    endcase
  end

  // mask resets clear
  // registers only; reset codes are zero until init picks the level
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= dlrc_pkg::DLRC_INIT;
      por_mid_reg <= 1'b0;
      mask_reg <= NUM_CHAN'(dlrc_pkg::LOAD_MASK_RST);
      gain_reg <= dlrc_pkg::SETUP_GAIN_RST;
      ref_off_reg <= dlrc_pkg::SETUP_REF_RST;
      input_reg <= '0;
      dac_reg <= '0;
    end else begin
      state_reg <= state_next;
      por_mid_reg <= por_mid_next;
      mask_reg <= mask_next;
      gain_reg <= gain_next;
      ref_off_reg <= ref_off_next;
      input_reg <= input_next;
      dac_reg <= dac_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs from flip-flops; INIT_DONE decoded from state_reg
  // ---------------------------------------------------------------
  assign DAC_CODE = dac_reg;
  assign LOAD_MASK = mask_reg;
  assign GAIN_TWO = gain_reg;
  assign REF_DISABLE = ref_off_reg;
  assign INIT_DONE = (state_reg == dlrc_pkg::DLRC_RUN);

endmodule : dlrc_top

`default_nettype wire

// file: testbench/dlrc_host.sv
// serial host model that frames command words for the control block
`timescale 1ns/1ps
`default_nettype none
module dlrc_host (
  output logic SCLK,
  output logic SYNC_N,
  output logic SDI
);
  // link idles with the clock stopped low and the frame closed
  initial begin
    SCLK = 1'b0;
    SYNC_N = 1'b1;
    SDI = 1'b0;
  end
  task automatic send(input logic [23:0] w);
    SYNC_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      SDI = w[i];
      #24 SCLK = 1'b1;
      #24 SCLK = 1'b0;
    end
    #24 SYNC_N = 1'b1;
    // data line is not held after the frame, so show a changed level
    SDI = ~w[0];
    // gap well above four system cycles so the word is taken first
    #400;
  endtask : send
endmodule : dlrc_host
`default_nettype wire

// file: testbench/dlrc_top_assertions.sv
// concurrent checks on the ports of the load and reset control block
`timescale 1ns/1ps
`default_nettype none
module dlrc_top_assertions #(parameter int NUM_CHAN = 8,
  parameter int CODE_BITS = 16, parameter bit HAS_CLEAR_SELECT = 1'b1) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SYNC_N,
  input wire logic LOAD_STROBE_N,
  input wire logic CLEAR_N,
  input wire logic CLEAR_LEVEL_SELECT,
  input wire logic [NUM_CHAN-1:0][CODE_BITS-1:0] DAC_CODE,
  input wire logic [NUM_CHAN-1:0] LOAD_MASK,
  input wire logic GAIN_TWO,
  input wire logic REF_DISABLE,
  input wire logic INIT_DONE
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [CODE_BITS-1:0] clr_code;
  // live select; the bench keeps it steady around clears and init
  assign clr_code = (HAS_CLEAR_SELECT && CLEAR_LEVEL_SELECT) ?
    dlrc_pkg::CODE_MID : dlrc_pkg::CODE_ZERO;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_mask_rst;
    $rose(RSTN) |-> LOAD_MASK == '0;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask not clear");
  property p_init_quiet;
    !INIT_DONE |-> LOAD_MASK == '0 && !GAIN_TWO && !REF_DISABLE;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("init moved");
  property p_clr_hold_init;
    !CLEAR_N [*4] |-> !$rose(INIT_DONE);
  endproperty
  a_clr_hold_init: assert property (p_clr_hold_init)
    else $error("early");
  property p_clr_stall;
    !INIT_DONE && !CLEAR_N |=> !INIT_DONE;
  endproperty
  a_clr_stall: assert property (p_clr_stall) else $error("init ran");
  property p_pwr_code;
    $rose(INIT_DONE) |-> DAC_CODE == {NUM_CHAN{clr_code}};
  endproperty
  a_pwr_code: assert property (p_pwr_code)
    else $error("bad power code");
  property p_clr_code;
    (INIT_DONE && !CLEAR_N) [*4] |-> DAC_CODE == {NUM_CHAN{clr_code}};
  endproperty
  a_clr_code: assert property (p_clr_code)
    else $error("bad clear code");
  property p_clr_release;
    INIT_DONE && $rose(CLEAR_N) |=> $stable(DAC_CODE) [*4];
  endproperty
  a_clr_release: assert property (p_clr_release) else $error("lost");
  property p_mask_block;
    (SYNC_N && CLEAR_N && INIT_DONE && LOAD_MASK == '1) [*6]
      |=> $stable(DAC_CODE);
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked");
  property p_quiet_link;
    SYNC_N [*6] |=> $stable({LOAD_MASK, GAIN_TWO, REF_DISABLE});
  endproperty
  a_quiet_link: assert property (p_quiet_link) else $error("no frame");
  c_strobe: cover property ($fell(LOAD_STROBE_N) && INIT_DONE);
  c_frame: cover property ($rose(SYNC_N) && INIT_DONE);
  c_clear: cover property (INIT_DONE && $fell(CLEAR_N));
endmodule : dlrc_top_assertions
bind dlrc_top dlrc_top_assertions #(.NUM_CHAN(NUM_CHAN),
  .CODE_BITS(CODE_BITS), .HAS_CLEAR_SELECT(HAS_CLEAR_SELECT))
  dlrc_top_assertions_i (.CLK, .RSTN, .SYNC_N, .LOAD_STROBE_N, .CLEAR_N,
  .CLEAR_LEVEL_SELECT, .DAC_CODE, .LOAD_MASK, .GAIN_TWO, .REF_DISABLE,
  .INIT_DONE);
`default_nettype wire

// file: testbench/dlrc_top_test.sv
// self-checking bench for the load and reset control block
`timescale 1ns/1ps
`default_nettype none
module dlrc_top_test;
  logic CLK, RSTN, LOAD_STROBE_N, CLEAR_N, CLEAR_LEVEL_SELECT;
  wire logic SCLK, SYNC_N, SDI;
  logic [7:0][15:0] DAC_CODE;
  logic [7:0] LOAD_MASK, setup;
  logic GAIN_TWO, REF_DISABLE, INIT_DONE;
  int err_total = 0;
  int checks = 0;
  assign setup = {6'h0, GAIN_TWO, REF_DISABLE};
  dlrc_host dlrc_host_i (.SCLK, .SYNC_N, .SDI);
  dlrc_top dlrc_top_i (.CLK, .RSTN, .SCLK, .SYNC_N, .SDI, .LOAD_STROBE_N,
    .CLEAR_N, .CLEAR_LEVEL_SELECT, .DAC_CODE, .LOAD_MASK, .GAIN_TWO,
    .REF_DISABLE, .INIT_DONE);
  // 40 mhz system clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk_code(input int c, input logic [15:0] e);
    checks++;
    if (DAC_CODE[c] !== e) begin
      err_total++;
      $display("unexpected dac_code %0d exp %h got %h", c, e, DAC_CODE[c]);
    end
  endtask : chk_code
  task automatic chk_reg(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_all(input logic [15:0] e);
    for (int c = 0; c < 8; c++) chk_code(c, e);
  endtask : chk_all
  // each word goes out whole; outputs settle inside the host's gap
  task automatic frame(input logic [3:0] c, a, input logic [15:0] d);
    dlrc_host_i.send({c, a, d});
    @(negedge CLK);
  endtask : frame
  task automatic strobe();
    LOAD_STROBE_N = 1'b0;
    repeat (6) @(negedge CLK);
    LOAD_STROBE_N = 1'b1;
    repeat (6) @(negedge CLK);
  endtask : strobe
  task automatic do_reset(input logic sel);
    RSTN = 1'b0;
    CLEAR_LEVEL_SELECT = sel;
    repeat (3) @(negedge CLK);
    RSTN = 1'b1;
  endtask : do_reset
  task automatic wait_init();
    for (int i = 0; i < 40 && INIT_DONE !== 1'b1; i++) @(negedge CLK);
    chk_reg("init_done", 8'h01, {7'h0, INIT_DONE});
  endtask : wait_init
  // main sequence; a strobe fall during init must leave no trace
  initial begin
    LOAD_STROBE_N = 1'b1;
    CLEAR_N = 1'b0;
    do_reset(1'b1);
    repeat (10) @(negedge CLK);
    LOAD_STROBE_N = 1'b0;
    repeat (6) @(negedge CLK);
    chk_reg("init_done", 8'h00, {7'h0, INIT_DONE});
    chk_reg("load_mask", 8'h00, LOAD_MASK);
    chk_reg("setup", 8'h00, setup);
    CLEAR_N = 1'b1;
    wait_init();
    LOAD_STROBE_N = 1'b1;
    repeat (6) @(negedge CLK);
    chk_all(16'h8000);
    $display("test powerup done");
    frame(4'h1, 4'h2, 16'h1111);
    chk_code(2, 16'h8000);
    strobe();
    chk_code(2, 16'h1111);
    frame(4'h5, 4'h9, 16'hab04);
    chk_reg("load_mask", 8'h04, LOAD_MASK);
    frame(4'h1, 4'h2, 16'h2222);
    frame(4'h1, 4'h3, 16'h3333);
    strobe();
    chk_code(2, 16'h1111);
    chk_code(3, 16'h3333);
    $display("test mask done");
    frame(4'h1, 4'h4, 16'h4444);
    frame(4'h2, 4'h0, 16'h0004);
    chk_code(2, 16'h2222);
    chk_code(4, 16'h8000);
    LOAD_STROBE_N = 1'b0;
    repeat (6) @(negedge CLK);
    frame(4'h1, 4'h2, 16'h5555);
    chk_code(2, 16'h5555);
    LOAD_STROBE_N = 1'b1;
    frame(4'h5, 4'h0, 16'h00ff);
    frame(4'h1, 4'h4, 16'h4545);
    frame(4'h1, 4'h5, 16'h6666);
    strobe();
    chk_code(4, 16'h4444);
    chk_code(5, 16'h8000);
    frame(4'h3, 4'h6, 16'h7777);
    chk_code(6, 16'h7777);
    $display("test update done");
    frame(4'h7, 4'hf, 16'hfffd);
    chk_reg("setup", 8'h03, setup);
    frame(4'h6, 4'h0, 16'h1235);
    frame(4'h6, 4'h1, 16'h1234);
    chk_code(6, 16'h7777);
    chk_reg("load_mask", 8'hff, LOAD_MASK);
    frame(4'h6, 4'h0, 16'h1234);
    chk_all(16'h8000);
    chk_reg("load_mask", 8'h00, LOAD_MASK);
    chk_reg("setup", 8'h00, setup);
    $display("test setup and key done");
    CLEAR_LEVEL_SELECT = 1'b0;
    repeat (4) @(negedge CLK);
    CLEAR_N = 1'b0;
    repeat (8) @(negedge CLK);
    chk_all(16'h0000);
    frame(4'h3, 4'h1, 16'h7777);
    chk_code(1, 16'h0000);
    CLEAR_N = 1'b1;
    repeat (8) @(negedge CLK);
    chk_code(1, 16'h0000);
    frame(4'h3, 4'h1, 16'h7777);
    chk_code(1, 16'h7777);
    $display("test clear done");
    do_reset(1'b0);
    wait_init();
    chk_all(16'h0000);
    $display("test reset done");
    report_and_stop();
  end
  // watchdog well beyond the expected run of some thirty microseconds
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
endmodule : dlrc_top_test
`default_nettype wire
